// ===== rtl/combined_pwm.v
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module combined_pwm (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Control
   input  wire [1:0]  mode,
   input  wire        run,
   input  wire        tick,
   // Shared counter and registers of both channels
   input  wire [15:0] count0,
   input  wire [15:0] period,
   input  wire [15:0] duty_u,
   input  wire [15:0] duty_v,
   input  wire [15:0] duty_w,
   input  wire [7:0]  dead,
   // Pin drive, bit 0 is channel 0 pin a, bit 7 channel 1 pin d
   output reg  [7:0]  out_q,
   output wire [7:0]  oe
);

   reg  [15:0] tri_q;
   reg         down_q;
   reg  [2:0]  raw_q;
   reg  [7:0]  dtc_q [0:2];
   reg  [2:0]  raw;
   reg  [2:0]  pos;
   reg  [2:0]  neg;
   wire        comp  = (mode == `MODE_COMPLEMENTARY);
   wire [15:0] base  = comp ? tri_q : count0;
   wire [7:0]  dwell = comp ? dead : 8'h00;
   integer     p;
   integer     q;

   // Triangle carrier for the complementary mode
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tri_q  <= 16'h0000;
         down_q <= 1'b0;
      end else if (!comp || period == 16'h0000) begin
         tri_q  <= 16'h0000;
         down_q <= 1'b0;
      end else if (run && tick) begin
         if (!down_q && tri_q >= period) begin
            tri_q  <= tri_q - 16'h0001; // RULE8
            down_q <= 1'b1;
         end else if (down_q && tri_q == 16'h0000) begin
            tri_q  <= 16'h0001;
            down_q <= 1'b0;
         end else begin
            tri_q <= down_q ? tri_q - 16'h0001 : tri_q + 16'h0001;
         end
      end
   end

   // Phase levels and dead-time qualified pairs
   always @* begin
      raw[0] = base < duty_u;
      raw[1] = base < duty_v;
      raw[2] = base < duty_w;
      for (p = 0; p < 3; p = p + 1) begin
         pos[p] = raw_q[p] & (dtc_q[p] >= dwell); // RULE8
         neg[p] = ~raw_q[p] & (dtc_q[p] >= dwell); // RULE7
      end
   end

   // Dwell counters restart on every phase edge so both sides stay low
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         raw_q <= 3'b000;
         for (q = 0; q < 3; q = q + 1) begin
            dtc_q[q] <= 8'h00;
         end
      end else begin
         raw_q <= raw;
         for (q = 0; q < 3; q = q + 1) begin
            if (raw[q] != raw_q[q]) begin
               dtc_q[q] <= 8'h00;
            end else if (dtc_q[q] != 8'hFF) begin
               dtc_q[q] <= dtc_q[q] + 8'h01;
            end
         end
      end
   end

   // Pin assignment follows the active mode
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= 8'h00;
      end else begin
         case (mode)
            `MODE_RESET_SYNC,
            `MODE_COMPLEMENTARY: begin
               out_q <= {neg[2], neg[1], pos[2], pos[1], neg[0], 1'b0, pos[0], 1'b0}; // RULE12
            end
            `MODE_FIXED_PERIOD: begin
               out_q <= {3'b000, count0 < duty_v, 3'b000, count0 < duty_u}; // RULE9
            end
            default: begin
               out_q <= 8'h00;
            end
         endcase
      end
   end

   assign oe = (mode == `MODE_FIXED_PERIOD) ? 8'h11 :
               (mode == `MODE_TIMER)        ? 8'h00 : 8'hFA;

endmodule // combined_pwm

// ===== rtl/dual_timer_capture_pwm.v
// Behaviour
// (RULE1) Two independent sixteen-bit counters
// (RULE2) Four bidirectional pins per channel
// (RULE3) Count source system clock or oscillator
// (RULE4) Capture copies counter on pin edge
// (RULE5) Compare match detected, may toggle pin
// (RULE6) PWM pin pulse width fully programmable
// (RULE7) Reset-synchronous mode: six outputs, no dead
// (RULE8) Complementary mode: triangle carrier with dead time
// (RULE9) Fixed-period mode: two PWM outputs
// (RULE10) Functions identical, selectable per pin
// (RULE11) Functions mix freely across both channels
// (RULE12) Combined modes share counters, pins per mode
// (RULE13) Channel zero pin a doubles as clock
// (RULE14) Counter runs only while start bit set
// (RULE15) Reset clears state and releases pins
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module dual_timer_capture_pwm (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Register port
   input  wire [19:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr_en,
   input  wire        rd_en,
   output reg  [7:0]  rdata,
   // Oscillator count source, asynchronous
   input  wire        hoco_clk_in,
   // Event link output, one cycle per channel 0 pin a match
   output reg         elc_event,
   // Channel 0 pins
   input  wire        ch0_pin_a_in,
   output wire        ch0_pin_a_out,
   output wire        ch0_pin_a_oe,
   input  wire        ch0_pin_b_in,
   output wire        ch0_pin_b_out,
   output wire        ch0_pin_b_oe,
   input  wire        ch0_pin_c_in,
   output wire        ch0_pin_c_out,
   output wire        ch0_pin_c_oe,
   input  wire        ch0_pin_d_in,
   output wire        ch0_pin_d_out,
   output wire        ch0_pin_d_oe,
   // Channel 1 pins
   input  wire        ch1_pin_a_in,
   output wire        ch1_pin_a_out,
   output wire        ch1_pin_a_oe,
   input  wire        ch1_pin_b_in,
   output wire        ch1_pin_b_out,
   output wire        ch1_pin_b_oe,
   input  wire        ch1_pin_c_in,
   output wire        ch1_pin_c_out,
   output wire        ch1_pin_c_oe,
   input  wire        ch1_pin_d_in,
   output wire        ch1_pin_d_out,
   output wire        ch1_pin_d_oe
);

   // Software registers
   reg  [7:0]  clken_q;
   reg  [7:0]  elc_ctrl_q;
   reg  [7:0]  start_q;
   reg  [7:0]  mode_sel_q;
   reg  [7:0]  func0_q;
   reg  [7:0]  func1_q;
   reg  [7:0]  dead_q;
   reg  [7:0]  status_q;
   reg  [7:0]  status_d;
   reg  [15:0] gen_q [0:7];
   // Pin and oscillator synchronisers
   reg  [8:0]  sync1_q;
   reg  [8:0]  sync2_q;
   reg  [8:0]  sync3_q;
   // Pin drive registers
   reg  [7:0]  pin_out_q;
   reg  [7:0]  pin_oe_q;
   reg  [7:0]  rdata_d;
   reg         tick;
   // Channel results
   wire [15:0] count0;
   wire [15:0] count1;
   wire [3:0]  cap0;
   wire [3:0]  cap1;
   wire [3:0]  match0;
   wire [3:0]  match1;
   wire [3:0]  tout0;
   wire [3:0]  tout1;
   wire [3:0]  toe0;
   wire [3:0]  toe1;
   wire [7:0]  cout;
   wire [7:0]  coe;
   wire [7:0]  pin_in;
   wire [8:0]  rise;
   wire [1:0]  mode;
   wire [1:0]  src;
   wire [7:0]  cap_all;
   wire [19:0] gen_off;
   wire        gen_hit;
   wire        combined;
   integer     k;

   // Exact address compare for a write
   function wr_hit;
      input [19:0] a;
      input [19:0] target;
      input        we;
      begin
         wr_hit = we & (a == target);
      end
   endfunction

   // Byte lane of a sixteen-bit value
   function [7:0] byte_of;
      input [15:0] v;
      input        hi;
      begin
         byte_of = hi ? v[15:8] : v[7:0];
      end
   endfunction

   assign pin_in   = {ch1_pin_d_in, ch1_pin_c_in, ch1_pin_b_in, ch1_pin_a_in,
                      ch0_pin_d_in, ch0_pin_c_in, ch0_pin_b_in, ch0_pin_a_in}; // RULE2
   assign mode     = mode_sel_q[`MODE_HI:`MODE_LO];
   assign src      = mode_sel_q[`SRC_HI:`SRC_LO];
   assign combined = (mode != `MODE_TIMER);
   assign cap_all  = {cap1, cap0};
   assign gen_off  = addr - `ADDR_GEN_BASE;
   assign gen_hit  = (addr >= `ADDR_GEN_BASE) && (addr <= `ADDR_GEN_LAST);

   // Two flops before any logic, third flop only for edge detect
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
         sync3_q <= 9'h000;
      end else begin
         sync1_q <= {hoco_clk_in, pin_in};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~sync3_q;

   // Count source pick; the oscillator must run below half of clk to be seen
   always @* begin
      case (src)
         `SRC_HOCO:      tick = rise[8]; // RULE3
         `SRC_EXT_CLOCK: tick = rise[0]; // RULE13
         default:        tick = 1'b1;
      endcase
      tick = tick & clken_q[`CLOCK_EN_TIMER_BIT];
   end

   // Control registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clken_q    <= `RST_CLOCK_EN;
         elc_ctrl_q <= `RST_EVENT_LINK;
         start_q    <= `RST_START_CTRL;
         mode_sel_q <= `RST_MODE_SEL;
         func0_q    <= `RST_PIN_FUNC;
         func1_q    <= `RST_PIN_FUNC;
         dead_q     <= `RST_DEAD_TIME;
      end else begin
         if (wr_hit(addr, `ADDR_CLOCK_EN, wr_en))     clken_q    <= wdata;
         if (wr_hit(addr, `ADDR_EVENT_LINK, wr_en))   elc_ctrl_q <= wdata;
         if (wr_hit(addr, `ADDR_START_CTRL, wr_en))   start_q    <= wdata; // RULE14
         if (wr_hit(addr, `ADDR_MODE_SEL, wr_en))     mode_sel_q <= wdata;
         if (wr_hit(addr, `ADDR_PIN_FUNC0, wr_en))    func0_q    <= wdata; // RULE10
         if (wr_hit(addr, `ADDR_PIN_FUNC1, wr_en))    func1_q    <= wdata; // RULE11
         if (wr_hit(addr, `ADDR_DEAD_TIME, wr_en))    dead_q     <= wdata;
      end
   end

   // General registers; a capture outranks a software write in the same cycle
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (k = 0; k < 8; k = k + 1) begin
            gen_q[k] <= 16'h0000; // RULE15
         end
      end else begin
         for (k = 0; k < 8; k = k + 1) begin
            if (cap_all[k] && !combined) begin
               gen_q[k] <= (k < 4) ? count0 : count1; // RULE4
            end else if (wr_en && gen_hit && gen_off[3:1] == k[2:0]) begin
               if (gen_off[0]) begin
                  gen_q[k][15:8] <= wdata;
               end else begin
                  gen_q[k][7:0] <= wdata;
               end
            end
         end
      end
   end

   // Sticky event flags, write one to clear; a new event beats the clear
   always @* begin
      status_d = status_q;
      if (wr_hit(addr, `ADDR_EVENT_STATUS, wr_en)) begin
         status_d = status_q & ~wdata;
      end
      status_d = status_d | cap_all | {match1, match0};
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q  <= 8'h00;
         elc_event <= 1'b0;
      end else begin
         status_q  <= status_d;
         elc_event <= elc_ctrl_q[`ELC_MATCH_EN_BIT] & match0[0];
      end
   end

   // Channel 0; in combined modes it carries the shared period
   timer_channel u_ch0 (
      .clk        (clk),
      .reset_n    (reset_n),
      .run        (start_q[`START_CH0_BIT]),
      .tick       (tick),
      .clear_on_a (mode == `MODE_RESET_SYNC || mode == `MODE_FIXED_PERIOD),
      .func       (combined ? 8'h00 : func0_q),
      .gen_flat   ({gen_q[3], gen_q[2], gen_q[1], gen_q[0]}),
      .pin_rise   (rise[3:0]),
      .count_q    (count0),
      .capture    (cap0),
      .match      (match0),
      .out_q      (tout0),
      .oe         (toe0)
   ); // RULE1

   // Channel 1
   timer_channel u_ch1 (
      .clk        (clk),
      .reset_n    (reset_n),
      .run        (start_q[`START_CH1_BIT]),
      .tick       (tick),
      .clear_on_a (1'b0),
      .func       (combined ? 8'h00 : func1_q),
      .gen_flat   ({gen_q[7], gen_q[6], gen_q[5], gen_q[4]}),
      .pin_rise   (rise[7:4]),
      .count_q    (count1),
      .capture    (cap1),
      .match      (match1),
      .out_q      (tout1),
      .oe         (toe1)
   ); // RULE1

   // Three-phase and fixed-period waveforms from both channels' registers
   combined_pwm u_comb (
      .clk     (clk),
      .reset_n (reset_n),
      .mode    (mode),
      .run     (start_q[`START_CH0_BIT]),
      .tick    (tick),
      .count0  (count0),
      .period  (gen_q[0]),
      .duty_u  (gen_q[1]),
      .duty_v  (gen_q[4]),
      .duty_w  (gen_q[5]),
      .dead    (dead_q),
      .out_q   (cout),
      .oe      (coe)
   ); // RULE12

   // Pin drive follows the active mode
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_q <= 8'h00;
         pin_oe_q  <= 8'h00; // RULE15
      end else if (combined) begin
         pin_out_q <= cout; // RULE12
         pin_oe_q  <= coe;
      end else begin
         pin_out_q <= {tout1, tout0}; // RULE11
         pin_oe_q  <= {toe1, toe0};
      end
   end

   assign ch0_pin_a_out = pin_out_q[0];
   assign ch0_pin_b_out = pin_out_q[1];
   assign ch0_pin_c_out = pin_out_q[2];
   assign ch0_pin_d_out = pin_out_q[3];
   assign ch1_pin_a_out = pin_out_q[4];
   assign ch1_pin_b_out = pin_out_q[5];
   assign ch1_pin_c_out = pin_out_q[6];
   assign ch1_pin_d_out = pin_out_q[7];
   assign ch0_pin_a_oe  = pin_oe_q[0];
   assign ch0_pin_b_oe  = pin_oe_q[1];
   assign ch0_pin_c_oe  = pin_oe_q[2];
   assign ch0_pin_d_oe  = pin_oe_q[3];
   assign ch1_pin_a_oe  = pin_oe_q[4];
   assign ch1_pin_b_oe  = pin_oe_q[5];
   assign ch1_pin_c_oe  = pin_oe_q[6];
   assign ch1_pin_d_oe  = pin_oe_q[7];

   // Read decode; unmapped addresses read zero
   always @* begin
      rdata_d = 8'h00;
      case (addr)
         `ADDR_CLOCK_EN:     rdata_d = clken_q;
         `ADDR_EVENT_LINK:   rdata_d = elc_ctrl_q;
         `ADDR_START_CTRL:   rdata_d = start_q;
         `ADDR_MODE_SEL:     rdata_d = mode_sel_q;
         `ADDR_PIN_FUNC0:    rdata_d = func0_q;
         `ADDR_PIN_FUNC1:    rdata_d = func1_q;
         `ADDR_DEAD_TIME:    rdata_d = dead_q;
         `ADDR_EVENT_STATUS: rdata_d = status_q;
         `ADDR_COUNT0_LO:    rdata_d = byte_of(count0, 1'b0);
         `ADDR_COUNT0_HI:    rdata_d = byte_of(count0, 1'b1);
         `ADDR_COUNT1_LO:    rdata_d = byte_of(count1, 1'b0);
         `ADDR_COUNT1_HI:    rdata_d = byte_of(count1, 1'b1);
         default: begin
            if (gen_hit) begin
               rdata_d = byte_of(gen_q[gen_off[3:1]], gen_off[0]);
            end
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd_en ? rdata_d : 8'h00;
      end
   end

endmodule // dual_timer_capture_pwm

// ===== rtl/dual_timer_map.vh
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

// Register byte addresses
`define ADDR_CLOCK_EN         20'hF_007A
`define ADDR_EVENT_LINK       20'hF_0260
`define ADDR_START_CTRL       20'hF_0263
`define ADDR_MODE_SEL         20'hF_0264
`define ADDR_PIN_FUNC0        20'hF_0280
`define ADDR_PIN_FUNC1        20'hF_0281
`define ADDR_DEAD_TIME        20'hF_0282
`define ADDR_EVENT_STATUS     20'hF_0283
`define ADDR_COUNT0_LO        20'hF_0284
`define ADDR_COUNT0_HI        20'hF_0285
`define ADDR_COUNT1_LO        20'hF_0286
`define ADDR_COUNT1_HI        20'hF_0287
`define ADDR_GEN_BASE         20'hF_0288
`define ADDR_GEN_LAST         20'hF_0297

// Reset values
`define RST_CLOCK_EN          8'h00
`define RST_EVENT_LINK        8'h00
`define RST_START_CTRL        8'h0C
`define RST_MODE_SEL          8'h00
`define RST_PIN_FUNC          8'h00
`define RST_DEAD_TIME         8'h00

// Field positions
`define CLOCK_EN_TIMER_BIT    4
`define ELC_MATCH_EN_BIT      0
`define START_CH0_BIT         0
`define START_CH1_BIT         1
`define MODE_HI               1
`define MODE_LO               0
`define SRC_HI                5
`define SRC_LO                4

// Timer and combined mode codes
`define MODE_TIMER            2'h0
`define MODE_RESET_SYNC       2'h1
`define MODE_COMPLEMENTARY    2'h2
`define MODE_FIXED_PERIOD     2'h3

// Count source codes
`define SRC_SYSTEM            2'h0
`define SRC_HOCO              2'h1
`define SRC_EXT_CLOCK         2'h2

// Per-pin function codes
`define FUNC_OFF              2'h0
`define FUNC_CAPTURE          2'h1
`define FUNC_COMPARE          2'h2
`define FUNC_PWM              2'h3

`endif

// ===== rtl/timer_channel.v
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module timer_channel (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Count control
   input  wire        run,
   input  wire        tick,
   input  wire        clear_on_a,
   // Pin functions and general registers, pin d in the top bits
   input  wire [7:0]  func,
   input  wire [63:0] gen_flat,
   input  wire [3:0]  pin_rise,
   // Results
   output reg  [15:0] count_q,
   output wire [3:0]  capture,
   output wire [3:0]  match,
   output reg  [3:0]  out_q,
   output wire [3:0]  oe
);

   wire step = run & tick;

   // Counter, held while the start bit is low
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= 16'h0000; // RULE15
      end else if (step) begin // RULE14
         // At or past the period, so a counter left high by another mode still wraps
         if (clear_on_a && (count_q >= gen_flat[15:0])) begin
            count_q <= 16'h0000;
         end else begin
            count_q <= count_q + 16'h0001; // RULE1
         end
      end
   end

   // One identical slice per pin, function picked per pin
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : pin
         wire [1:0]  sel = func[2*i+1:2*i];
         wire [15:0] gen = gen_flat[16*i+15:16*i];
         assign match[i]   = step & (count_q == gen); // RULE5
         assign capture[i] = (sel == `FUNC_CAPTURE) & pin_rise[i]; // RULE4
         assign oe[i]      = (sel == `FUNC_COMPARE) | (sel == `FUNC_PWM); // RULE10
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               out_q[i] <= 1'b0;
            end else if (sel == `FUNC_COMPARE) begin
               if (match[i]) begin
                  out_q[i] <= ~out_q[i]; // RULE5
               end
            end else if (sel == `FUNC_PWM) begin
               out_q[i] <= (count_q < gen); // RULE6
            end else begin
               out_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule // timer_channel

// ===== tb/dual_timer_capture_pwm_tb.sv
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module dual_timer_capture_pwm_tb;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hoco = 1'b0;
   logic [19:0] addr = 20'h0_0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [7:0]  ext = 8'h00;
   wire  [7:0]  rdata;
   wire         elc_event;
   wire  [7:0]  p_out;
   wire  [7:0]  p_oe;
   wire  [7:0]  p_in;
   int          mismatches = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          n0;
   int          n1;
   logic [15:0] v0;
   logic [15:0] v1;
   logic [15:0] t;
   logic [7:0]  b;

   always #10 clk = ~clk;
   // Slow oscillator, seen through the synchroniser
   always #50 hoco = ~hoco;

   dual_timer_capture_pwm dual_timer_capture_pwm_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .hoco_clk_in(hoco), .elc_event(elc_event),
      .ch0_pin_a_in(p_in[0]), .ch0_pin_a_out(p_out[0]), .ch0_pin_a_oe(p_oe[0]),
      .ch0_pin_b_in(p_in[1]), .ch0_pin_b_out(p_out[1]), .ch0_pin_b_oe(p_oe[1]),
      .ch0_pin_c_in(p_in[2]), .ch0_pin_c_out(p_out[2]), .ch0_pin_c_oe(p_oe[2]),
      .ch0_pin_d_in(p_in[3]), .ch0_pin_d_out(p_out[3]), .ch0_pin_d_oe(p_oe[3]),
      .ch1_pin_a_in(p_in[4]), .ch1_pin_a_out(p_out[4]), .ch1_pin_a_oe(p_oe[4]),
      .ch1_pin_b_in(p_in[5]), .ch1_pin_b_out(p_out[5]), .ch1_pin_b_oe(p_oe[5]),
      .ch1_pin_c_in(p_in[6]), .ch1_pin_c_out(p_out[6]), .ch1_pin_c_oe(p_oe[6]),
      .ch1_pin_d_in(p_in[7]), .ch1_pin_d_out(p_out[7]), .ch1_pin_d_oe(p_oe[7]));

   pin_partner pin_partner_inst (.drv(p_out), .oe(p_oe), .ext(ext), .level(p_in));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [19:0] a, output logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask

   // No byte latch, so only read while the counter stands
   task automatic rd16(input logic [19:0] a, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(a, lo);
      rd(a + 20'h1, hi);
      v = {hi, lo};
   endtask

   task automatic wr16(input int k, input logic [15:0] v);
      wr(`ADDR_GEN_BASE + 20'(2 * k), v[7:0]);
      wr(`ADDR_GEN_BASE + 20'(2 * k + 1), v[15:8]);
   endtask

   task automatic high_cycles(input int i, output int n);
      n = 0;
      repeat (100) begin
         @(posedge clk);
         #1;
         if (p_out[i] === 1'b1 && p_oe[i] === 1'b1) n++;
      end
   endtask

   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rd(`ADDR_CLOCK_EN, b); chk(b, 16'h0000, "clken");
      rd(`ADDR_EVENT_LINK, b); chk(b, 16'h0000, "elc");
      rd(`ADDR_START_CTRL, b); chk(b, 16'h000C, "start");
      rd(`ADDR_MODE_SEL, b); chk(b, 16'h0000, "mode");
      rd(20'hF_0261, b); chk(b, 16'h0000, "unmapped");
      chk(p_oe, 16'h0000, "pins released");
      $display("reset_values done");
      // Counting gated by start bits
      wr(`ADDR_CLOCK_EN, 8'h10);
      repeat (10) @(posedge clk);
      rd16(`ADDR_COUNT0_LO, t); chk(t, 16'h0000, "held");
      wr(`ADDR_START_CTRL, 8'h0F);
      repeat (30) @(posedge clk);
      wr(`ADDR_START_CTRL, 8'h0C);
      rd16(`ADDR_COUNT0_LO, v0); chk(v0 > 16'd20, 16'h0001, "count0 ran");
      rd16(`ADDR_COUNT1_LO, v1); chk(v1 > 16'd20, 16'h0001, "count1 ran");
      wr(`ADDR_START_CTRL, 8'h0E);
      repeat (20) @(posedge clk);
      wr(`ADDR_START_CTRL, 8'h0C);
      rd16(`ADDR_COUNT0_LO, t); chk(t, v0, "count0 held");
      rd16(`ADDR_COUNT1_LO, t); chk(t > v1, 16'h0001, "count1 alone");
      v1 = t;
      $display("counting done");
      // Capture on pin b, counters standing; match flags from counting cleared first
      wr(`ADDR_EVENT_STATUS, 8'hFF);
      wr(`ADDR_PIN_FUNC0, 8'h04);
      wr(`ADDR_PIN_FUNC1, 8'h04);
      @(posedge clk);
      ext <= 8'h22;
      repeat (8) @(posedge clk);
      ext <= 8'h00;
      rd16(`ADDR_GEN_BASE + 20'h2, t); chk(t, v0, "capture ch0");
      rd16(`ADDR_GEN_BASE + 20'hA, t); chk(t, v1, "capture ch1");
      rd(`ADDR_EVENT_STATUS, b); chk(b, 16'h0022, "flags");
      wr(`ADDR_EVENT_STATUS, 8'h22);
      rd(`ADDR_EVENT_STATUS, b); chk(b, 16'h0000, "cleared");
      $display("capture done");
      // PWM on pin c beside capture on pin b
      wr16(2, v0 + 16'h1);
      wr(`ADDR_PIN_FUNC0, 8'h34);
      repeat (4) @(posedge clk);
      chk({p_oe[2], p_out[2]}, 16'h0003, "pwm high");
      wr16(2, v0);
      repeat (4) @(posedge clk);
      chk({p_oe[2], p_out[2]}, 16'h0002, "pwm low");
      $display("pwm done");
      // Compare toggle and one event
      wr(`ADDR_PIN_FUNC0, 8'h02);
      wr16(0, v0 + 16'h6);
      repeat (3) @(posedge clk);
      b[0] = p_out[0];
      wr(`ADDR_EVENT_LINK, 8'h01);
      wr(`ADDR_START_CTRL, 8'h0D);
      n0 = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (elc_event === 1'b1) n0++;
      end
      chk(n0, 16'h0001, "one event");
      chk({p_oe[0], p_out[0]}, {15'h0001, ~b[0]}, "toggle");
      wr(`ADDR_START_CTRL, 8'h0C);
      wr(`ADDR_EVENT_LINK, 8'h00);
      wr(`ADDR_PIN_FUNC0, 8'h00);
      $display("compare done");
      // Pin a clock, then oscillator
      rd16(`ADDR_COUNT0_LO, v0);
      wr(`ADDR_MODE_SEL, 8'h20);
      wr(`ADDR_START_CTRL, 8'h0D);
      repeat (5) begin
         ext <= 8'h01;
         repeat (4) @(posedge clk);
         ext <= 8'h00;
         repeat (4) @(posedge clk);
      end
      wr(`ADDR_START_CTRL, 8'h0C);
      rd16(`ADDR_COUNT0_LO, t); chk(t, v0 + 16'd5, "pin clock");
      wr(`ADDR_MODE_SEL, 8'h10);
      wr(`ADDR_START_CTRL, 8'h0D);
      repeat (100) @(posedge clk);
      wr(`ADDR_START_CTRL, 8'h0C);
      rd16(`ADDR_COUNT0_LO, v0); chk(v0 > t, 16'h0001, "osc count");
      $display("sources done");
      // Fresh reset before the combined modes
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      chk(p_oe, 16'h0000, "pins released");
      wr(`ADDR_CLOCK_EN, 8'h10);
      wr16(0, 16'd9);
      wr16(1, 16'd3);
      wr16(4, 16'd5);
      wr16(5, 16'd2);
      wr(`ADDR_DEAD_TIME, 8'h02);
      for (int m = 1; m <= 3; m++) begin
         wr(`ADDR_MODE_SEL, 8'(m));
         wr(`ADDR_START_CTRL, 8'h0F);
         repeat (30) @(posedge clk);
         chk(p_oe, (m == 3) ? 16'h0011 : 16'h00FA, "comb pins");
         n0 = 0;
         repeat (100) begin
            @(posedge clk);
            #1;
            if (m == 1 && p_out[1] === p_out[3]) n0++;
            if (m == 2 && (p_out[1] & p_out[3]) === 1'b1) n0++;
         end
         chk(n0, 16'h0000, "phase pair");
      end
      high_cycles(0, n0); chk(n0, 16'd30, "duty a");
      high_cycles(4, n1); chk(n1, 16'd50, "duty b");
      $display("combined done");
      stop_test();
   end
endmodule // dual_timer_capture_pwm_tb

// ===== tb/pin_partner.sv
`timescale 1ns/1ps

module pin_partner (
   // Design side
   input  wire logic [7:0] drv,
   input  wire logic [7:0] oe,
   // Outside source
   input  wire logic [7:0] ext,
   // Level on the pins
   output wire logic [7:0] level
);
   // A driven pin reads its own level, a released one the outside source
   assign level = (oe & drv) | (~oe & ext);
endmodule // pin_partner

// ===== tb/timer_props.sv
`timescale 1ns/1ps
`include "dual_timer_map.vh"

module timer_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Register port
   input wire logic [19:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  rdata,
   // Events and pin enables
   input wire logic        elc_event,
   input wire logic        ch0_pin_a_oe,
   input wire logic        ch0_pin_d_oe,
   input wire logic        ch1_pin_a_oe,
   input wire logic        ch1_pin_d_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [7:0] clken_q;
   logic [7:0] elc_q;
   logic [7:0] start_q;
   logic [7:0] mode_q;

   // Shadow registers
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clken_q <= `RST_CLOCK_EN;
         elc_q   <= `RST_EVENT_LINK;
         start_q <= `RST_START_CTRL;
         mode_q  <= `RST_MODE_SEL;
      end else if (wr_en) begin
         if (addr == `ADDR_CLOCK_EN) clken_q <= wdata;
         if (addr == `ADDR_EVENT_LINK) elc_q <= wdata;
         if (addr == `ADDR_START_CTRL) start_q <= wdata;
         if (addr == `ADDR_MODE_SEL) mode_q <= wdata;
      end
   end

   // Outputs still quiet at the first edge after reset
   chk_reset_quiet: assert property ($rose(reset_n) |->
      !(ch0_pin_a_oe | ch0_pin_d_oe | ch1_pin_a_oe | ch1_pin_d_oe | elc_event) && rdata == 8'h00)
      else $error("outputs active after reset");
   chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("stray read data");
   chk_unmapped_zero: assert property (rd_en && addr == 20'hF_0261 ##1 1'b1 |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_clken_read: assert property (rd_en && addr == `ADDR_CLOCK_EN |=> rdata == clken_q)
      else $error("clken readback");
   chk_elc_read: assert property (rd_en && addr == `ADDR_EVENT_LINK |=> rdata == $past(elc_q))
      else $error("elc readback");
   chk_start_read: assert property (rd_en && addr == `ADDR_START_CTRL |-> ##1 rdata == start_q)
      else $error("start readback");
   chk_mode_read: assert property ($past(rd_en && addr == `ADDR_MODE_SEL) |-> rdata == mode_q)
      else $error("mode readback");
   chk_event_single: assert property (elc_event |=> !elc_event)
      else $error("event pulse too long");
endmodule // timer_props

bind dual_timer_capture_pwm timer_props timer_props_inst (.*);
